// >>> inc/scs_pkg.sv
// Constants, field layouts and carriers of the serial command settings block.
package scs_pkg;
   // Register byte addresses.
   localparam logic [4:0] ADR_CMD = 5'h00;
   localparam logic [4:0] ADR_REPLY = 5'h04;
   localparam logic [4:0] ADR_STAT = 5'h08;
   localparam logic [4:0] ADR_BAUD = 5'h0C;
   localparam logic [4:0] ADR_BOOT = 5'h10;
   // Setting selectors.
   localparam logic [2:0] SET_REPLY = 3'h0;
   localparam logic [2:0] SET_AGC = 3'h1;
   localparam logic [2:0] SET_CEIL = 3'h2;
   localparam logic [2:0] SET_FLOOR = 3'h3;
   localparam logic [2:0] SET_RATE = 3'h4;
   localparam logic [2:0] SET_TONE = 3'h5;
   localparam logic [2:0] SET_DROP = 3'h6;
   // Command operations.
   localparam logic [1:0] OP_CMD = 2'h0;
   localparam logic [1:0] OP_SAVE = 2'h1;
   localparam logic [1:0] OP_RECALL = 2'h2;
   // Data and channel codes.
   localparam logic [7:0] DATA_OFF = 8'h00;
   localparam logic [7:0] DATA_ON = 8'h01;
   localparam logic [7:0] DATA_TOGGLE = 8'h02;
   localparam logic [7:0] DATA_QUERY = 8'h3F;
   localparam logic [7:0] CHAN_T = 8'h54;
   // Integer ranges.
   localparam logic signed [7:0] CEIL_MIN = 8'sh00;
   localparam logic signed [7:0] CEIL_MAX = 8'sh0F;
   localparam logic signed [7:0] FLOOR_MIN = 8'shF1;
   localparam logic signed [7:0] FLOOR_MAX = 8'sh00;
   localparam logic signed [7:0] RATE_MIN = 8'sh01;
   localparam logic signed [7:0] RATE_MAX = 8'sh05;
   // Reset values and serial rate codes.
   localparam logic RST_REPLY_EN = 1'b1;
   localparam logic signed [7:0] RST_CEIL = 8'sh0F;
   localparam logic signed [7:0] RST_FLOOR = 8'shF1;
   localparam logic [7:0] RST_RATE = 8'h03;
   localparam logic [1:0] BAUD_9600 = 2'h0;
   localparam logic [1:0] BAUD_19200 = 2'h1;
   localparam logic [1:0] BAUD_38400 = 2'h2;
   // Timing.
   localparam int CLK_HZ = 250000000;
   localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / 9600);
   localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / 19200);
   localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / 38400);
   localparam int RAMP_PERIOD_S = 1;
   localparam int RAMP_SEC_CYCLES = CLK_HZ * RAMP_PERIOD_S;
   // Carriers.
   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_IDLE = 3'b010,
      ST_NV = 3'b100
   } scs_state_e;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] chan;
      logic [2:0] rsv;
      logic [1:0] op;
      logic [2:0] setting;
   } scs_cmd_s;
   typedef struct packed {
      logic valid;
      logic err;
      logic [10:0] rsv;
      logic [2:0] setting;
      logic [7:0] chan;
      logic [7:0] data;
   } scs_reply_s;
   typedef struct packed {
      logic agc_en;
      logic signed [7:0] ceil;
      logic signed [7:0] floor;
      logic [7:0] rate;
      logic tone_en;
      logic drop_en;
   } scs_set_s;
   typedef struct packed {
      logic [15:0] rsv;
      logic [7:0] gain;
      logic [1:0] rsv2;
      logic preset_valid;
      logic busy;
      logic drop_en;
      logic tone_en;
      logic agc_en;
      logic reply_en;
   } scs_stat_s;
endpackage : scs_pkg

// >>> src/scs_command_settings.sv
// Command interpreter for the reply, gain control and auto hangup settings.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] Replies go out only while reply enable is on; it is on after reset.
// [R2] Every reply enable change is written to storage; reply waits for it.
// [R3] Boolean data 1 enables and 0 disables, then the new value is replied.
// [R4] Boolean data 2 inverts the state and replies the result.
// [R5] Boolean query leaves state unchanged and replies current state.
// [R6] Gain control settings apply only to channel letter T.
// [R7] Gain ceiling accepts 0 to 15; applied gain stays at or below it.
// [R8] Gain floor accepts -15 to 0; applied gain stays at or above it.
// [R9] Ramp rate accepts 1 to 5 and bounds gain steps per second.
// [R10] Integer writes reply with channel letter and the new stored value.
// [R11] Integer query leaves value unchanged and replies current value.
// [R12] Gain and hangup settings persist only in a preset, restored if chosen.
// [R13] With tone hangup on, detected busy or off-hook tones hang up.
// [R14] With current drop hangup on, a loop current drop hangs up.
// [R15] The two hangup enables are separate and act independently.
// [R16] Commands and replies carry type, id, command, channel and data; neither carrier has an id, and replies leave out the op.
// [R17] Serial port runs at 9600, 19200 or 38400 bits per second.
module scs_command_settings #(
   parameter int RAMP_SEC_CYCLES = scs_pkg::RAMP_SEC_CYCLES
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Storage write of the reply enable.
   output logic nv_req_o,
   output logic nv_data_o,
   input wire logic nv_done_i,
   // Line detectors and hook control.
   input wire logic tone_det_i,
   input wire logic drop_det_i,
   output logic hang_up_o,
   // Telephone input gain control.
   input wire logic signed [7:0] agc_target_i,
   output logic signed [7:0] agc_gain_o,
   // Serial port rate divisor.
   output logic [15:0] baud_div_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   scs_pkg::scs_state_e st;
   scs_pkg::scs_set_s cur;
   scs_pkg::scs_set_s next_set;
   scs_pkg::scs_set_s preset;
   scs_pkg::scs_reply_s reply_q;
   scs_pkg::scs_reply_s pend;
   scs_pkg::scs_reply_s next_reply;
   scs_pkg::scs_cmd_s cmd;
   scs_pkg::scs_stat_s stat;
   logic reply_en;
   logic next_reply_en;
   logic preset_valid;
   logic boot_en;
   logic [1:0] baud_sel;
   logic bus_req;
   logic cmd_go;
   logic rd_reply;
   logic nv_start;
   logic post_now;
   logic is_int;
   logic chan_bad;
   logic [1:0] b2;
   logic [8:0] i9;
   logic [2:0] tone_sync;
   logic [2:0] drop_sync;
   logic tone_det;
   logic drop_det;
   logic tone_rise;
   logic drop_rise;
   logic [31:0] ramp_acc;
   logic [31:0] ramp_sum;
   logic step;
   logic signed [7:0] aim;

   function automatic logic [1:0] scs_bool_f(input logic old, input logic [7:0] d);
      logic [1:0] r;
      r = {1'b0, old};
      if (d == scs_pkg::DATA_ON) begin
         r = 2'b01;
      end else if (d == scs_pkg::DATA_OFF) begin
         r = 2'b00;
      end else if (d == scs_pkg::DATA_TOGGLE) begin
         r = {1'b0, ~old};
      end else if (d != scs_pkg::DATA_QUERY) begin
         r = {1'b1, old};
      end
      return r;
   endfunction : scs_bool_f

   // [R11] query keeps value.
   function automatic logic [8:0] scs_int_f(input logic signed [7:0] old,
      input logic signed [7:0] d, input logic signed [7:0] lo, input logic signed [7:0] hi);
      logic [8:0] r;
      r = {1'b0, old};
      if (d != scs_pkg::DATA_QUERY) begin
         if (d >= lo && d <= hi) begin
            r = {1'b0, d};
         end else begin
            r = {1'b1, old};
         end
      end
      return r;
   endfunction : scs_int_f

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmd = scs_pkg::scs_cmd_s'(wb_dat_i[23:0]);
   assign cmd_go = bus_req && wb_we_i && wb_adr_i == scs_pkg::ADR_CMD
                   && (&wb_sel_i[2:0]) && st == scs_pkg::ST_IDLE;
   assign rd_reply = bus_req && !wb_we_i && wb_adr_i == scs_pkg::ADR_REPLY;

   // Decodes a command into the next settings and its reply.
   always_comb begin
      next_set = cur;
      next_reply_en = reply_en;
      b2 = 2'b00;
      i9 = 9'h000;
      is_int = 1'b0;
      chan_bad = 1'b0;
      case (cmd.setting)
         // [R3] [R4] [R5] boolean set, toggle, query.
         scs_pkg::SET_REPLY: begin
            b2 = scs_bool_f(reply_en, cmd.data);
            next_reply_en = b2[0];
         end
         // [R6] channel T only.
         scs_pkg::SET_AGC: begin
            b2 = scs_bool_f(cur.agc_en, cmd.data);
            next_set.agc_en = b2[0];
            chan_bad = cmd.chan != scs_pkg::CHAN_T;
         end
         // [R7] ceiling range.
         scs_pkg::SET_CEIL: begin
            i9 = scs_int_f(cur.ceil, cmd.data, scs_pkg::CEIL_MIN, scs_pkg::CEIL_MAX);
            next_set.ceil = i9[7:0];
            is_int = 1'b1;
            chan_bad = cmd.chan != scs_pkg::CHAN_T;
         end
         // [R8] floor range.
         scs_pkg::SET_FLOOR: begin
            i9 = scs_int_f(cur.floor, cmd.data, scs_pkg::FLOOR_MIN, scs_pkg::FLOOR_MAX);
            next_set.floor = i9[7:0];
            is_int = 1'b1;
            chan_bad = cmd.chan != scs_pkg::CHAN_T;
         end
         // [R9] rate range.
         scs_pkg::SET_RATE: begin
            i9 = scs_int_f(cur.rate, cmd.data, scs_pkg::RATE_MIN, scs_pkg::RATE_MAX);
            next_set.rate = i9[7:0];
            is_int = 1'b1;
            chan_bad = cmd.chan != scs_pkg::CHAN_T;
         end
         // [R15] separate hangup enables.
         scs_pkg::SET_TONE: begin
            b2 = scs_bool_f(cur.tone_en, cmd.data);
            next_set.tone_en = b2[0];
         end
         scs_pkg::SET_DROP: begin
            b2 = scs_bool_f(cur.drop_en, cmd.data);
            next_set.drop_en = b2[0];
         end
         default: begin
            b2 = 2'b10;
         end
      endcase
      next_reply = '0;
      next_reply.err = b2[1] || i9[8] || chan_bad;
      if (next_reply.err) begin
         next_set = cur;
         next_reply_en = reply_en;
      end
      // [R10] [R16] echo channel and stored value.
      next_reply.setting = cmd.setting;
      next_reply.chan = cmd.chan;
      next_reply.data = is_int ? i9[7:0] : {7'h00, b2[0]};
      if (next_reply.err) begin
         next_reply.data = cmd.data;
      end
   end

   // [R2] storage write on every accepted change.
   assign nv_start = cmd_go && cmd.op == scs_pkg::OP_CMD && !next_reply.err
                     && cmd.setting == scs_pkg::SET_REPLY && cmd.data != scs_pkg::DATA_QUERY;

   // Command sequencing, settings and storage handshake.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= scs_pkg::ST_BOOT;
         cur <= '{1'b0, scs_pkg::RST_CEIL, scs_pkg::RST_FLOOR, scs_pkg::RST_RATE, 1'b0, 1'b0};
         reply_en <= scs_pkg::RST_REPLY_EN;
         nv_req_o <= 1'b0;
         nv_data_o <= scs_pkg::RST_REPLY_EN;
         post_now <= 1'b0;
         pend <= '0;
      end else begin
         post_now <= 1'b0;
         case (st)
            scs_pkg::ST_BOOT: begin
               // [R12] power-up restore of the chosen preset.
               if (boot_en && preset_valid) begin
                  cur <= preset;
               end
               st <= scs_pkg::ST_IDLE;
            end
            scs_pkg::ST_IDLE: begin
               if (cmd_go && cmd.op == scs_pkg::OP_CMD) begin
                  cur <= next_set;
                  reply_en <= next_reply_en;
                  pend <= next_reply;
                  if (nv_start) begin
                     st <= scs_pkg::ST_NV;
                     nv_req_o <= 1'b1;
                     nv_data_o <= next_reply_en;
                  end else begin
                     post_now <= 1'b1;
                  end
               end else if (cmd_go && cmd.op == scs_pkg::OP_RECALL && preset_valid) begin
                  cur <= preset;
               end
            end
            scs_pkg::ST_NV: begin
               // [R2] reply held until the write completes.
               if (nv_done_i) begin
                  nv_req_o <= 1'b0;
                  post_now <= 1'b1;
                  st <= scs_pkg::ST_IDLE;
               end
            end
            default: begin
               st <= scs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Preset store and power-up choice survive a reset.
   always_ff @(posedge clk_i) begin
      // [R12] settings saved only within the preset.
      if (cmd_go && cmd.op == scs_pkg::OP_SAVE) begin
         preset <= cur;
         preset_valid <= 1'b1;
      end
      if (bus_req && wb_we_i && wb_adr_i == scs_pkg::ADR_BOOT && wb_sel_i[0]) begin
         boot_en <= wb_dat_i[0];
      end
   end

   // Reply register; a new reply wins over a read that clears it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reply_q <= '0;
      end else if (post_now && reply_en) begin
         // [R1] replies gated by the reply enable.
         reply_q <= pend;
         reply_q.valid <= 1'b1;
      end else if (rd_reply) begin
         reply_q.valid <= 1'b0;
      end
   end

   // Serial rate select and divisor.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_sel <= scs_pkg::BAUD_9600;
         baud_div_o <= scs_pkg::DIV_9600;
      end else begin
         // [R17] only the three listed rates are taken.
         if (bus_req && wb_we_i && wb_adr_i == scs_pkg::ADR_BAUD && wb_sel_i[0]
             && wb_dat_i[1:0] != 2'h3) begin
            baud_sel <= wb_dat_i[1:0];
         end
         if (baud_sel == scs_pkg::BAUD_38400) begin
            baud_div_o <= scs_pkg::DIV_38400;
         end else if (baud_sel == scs_pkg::BAUD_19200) begin
            baud_div_o <= scs_pkg::DIV_19200;
         end else begin
            baud_div_o <= scs_pkg::DIV_9600;
         end
      end
   end

   always_comb begin
      stat = '0;
      stat.reply_en = reply_en;
      stat.agc_en = cur.agc_en;
      stat.tone_en = cur.tone_en;
      stat.drop_en = cur.drop_en;
      stat.busy = st != scs_pkg::ST_IDLE;
      stat.preset_valid = preset_valid;
      stat.gain = agc_gain_o;
   end

   // Wishbone answer one cycle after the strobe.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h00000000;
         if (bus_req && !wb_we_i) begin
            if (wb_adr_i == scs_pkg::ADR_REPLY) begin
               wb_dat_o <= reply_q;
            end else if (wb_adr_i == scs_pkg::ADR_STAT) begin
               wb_dat_o <= stat;
            end else if (wb_adr_i == scs_pkg::ADR_BAUD) begin
               wb_dat_o <= {30'h00000000, baud_sel};
            end else if (wb_adr_i == scs_pkg::ADR_BOOT) begin
               wb_dat_o <= {31'h00000000, boot_en};
            end
         end
      end
   end

   assign tone_rise = tone_sync[2] == tone_sync[1] && tone_sync[1] && !tone_det;
   assign drop_rise = drop_sync[2] == drop_sync[1] && drop_sync[1] && !drop_det;

   // Detector synchronisers and hangup pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_sync <= 3'h0;
         drop_sync <= 3'h0;
         tone_det <= 1'b0;
         drop_det <= 1'b0;
         hang_up_o <= 1'b0;
      end else begin
         tone_sync <= {tone_sync[1:0], tone_det_i};
         drop_sync <= {drop_sync[1:0], drop_det_i};
         if (tone_sync[2] == tone_sync[1]) begin
            tone_det <= tone_sync[1];
         end
         if (drop_sync[2] == drop_sync[1]) begin
            drop_det <= drop_sync[1];
         end
         // [R13] [R14] [R15] each enable gates its own detector.
         hang_up_o <= (cur.tone_en && tone_rise) || (cur.drop_en && drop_rise);
      end
   end

   assign ramp_sum = ramp_acc + {24'h000000, cur.rate};
   assign step = ramp_sum >= 32'(RAMP_SEC_CYCLES);

   always_comb begin
      aim = agc_target_i;
      if (aim > cur.ceil) begin
         aim = cur.ceil;
      end else if (aim < cur.floor) begin
         aim = cur.floor;
      end
   end

   // Gain ramp; one dB per step, rate steps per second.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ramp_acc <= 32'h00000000;
         agc_gain_o <= 8'sh00;
      end else begin
         // [R9] step pacing from the ramp rate.
         ramp_acc <= step ? ramp_sum - 32'(RAMP_SEC_CYCLES) : ramp_sum;
         // [R7] [R8] clamp to ceiling and floor first.
         if (agc_gain_o > cur.ceil) begin
            agc_gain_o <= cur.ceil;
         end else if (agc_gain_o < cur.floor) begin
            agc_gain_o <= cur.floor;
         end else if (!cur.agc_en) begin
            agc_gain_o <= 8'sh00;
         end else if (step && agc_gain_o < aim) begin
            agc_gain_o <= agc_gain_o + 8'sh01;
         end else if (step && agc_gain_o > aim) begin
            agc_gain_o <= agc_gain_o - 8'sh01;
         end
      end
   end

   sequence s_nv_change;
      nv_start ##1 nv_req_o;
   endsequence
   sequence s_nv_finish;
      nv_req_o && nv_done_i ##1 !nv_req_o;
   endsequence

   a_reply_gate: assert property ($rose(reply_q.valid) |-> reply_en) // [R1]
      else $error("reply posted while replies are off");
   a_nv_hold: assert property (s_nv_change |-> !$rose(reply_q.valid) until nv_done_i) // [R2]
      else $error("reply left before the storage write ended");
   a_nv_post: assert property (s_nv_finish |-> ##1 (reply_q.valid || !reply_en)) // [R2]
      else $error("reply missing after the storage write");
   a_bool_toggle: assert property (cmd_go && cmd.op == scs_pkg::OP_CMD // [R4]
      && cmd.setting == scs_pkg::SET_TONE && cmd.data == scs_pkg::DATA_TOGGLE
      |=> cur.tone_en != $past(cur.tone_en))
      else $error("toggle did not invert the state");
   a_query_keeps: assert property (cmd_go && cmd.op == scs_pkg::OP_CMD // [R5]
      && cmd.data == scs_pkg::DATA_QUERY
      |=> cur == $past(cur) && reply_en == $past(reply_en))
      else $error("query changed a setting");
   a_chan_only: assert property (cmd_go && cmd.setting == scs_pkg::SET_CEIL // [R6]
      && cmd.chan != scs_pkg::CHAN_T |=> $stable(cur.ceil))
      else $error("ceiling changed from a channel other than T");
   a_gain_ceil: assert property (agc_gain_o <= $past(cur.ceil)) // [R7]
      else $error("gain above the ceiling");
   a_gain_floor: assert property (agc_gain_o >= $past(cur.floor)) // [R8]
      else $error("gain below the floor");
   a_rate_range: assert property (cur.rate >= 8'h01 && cur.rate <= 8'h05) // [R9]
      else $error("ramp rate out of range");
   a_int_echo: assert property (cmd_go && cmd.op == scs_pkg::OP_CMD && reply_en // [R10]
      && cmd.setting == scs_pkg::SET_RATE |-> ##2 reply_q.valid
      && reply_q.chan == $past(cmd.chan, 2))
      else $error("integer reply missing or wrong channel");
   a_hang_cause: assert property (hang_up_o |-> $past(cur.tone_en) || $past(cur.drop_en)) // [R15]
      else $error("hangup with both enables off");
endmodule : scs_command_settings
`default_nettype wire

// >>> bench/scs_nv_model.sv
// Storage model that completes each reply enable write after a set latency.
`timescale 1ns/1ps
`default_nettype none
module scs_nv_model (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Storage handshake.
   input wire logic nv_req_i,
   input wire logic [7:0] lat_i,
   output logic nv_done_o
);
   logic [7:0] waited;
   always_ff @(posedge clk_i) begin
      if (rst_i || !nv_req_i || nv_done_o) begin
         waited <= 8'h00;
         nv_done_o <= 1'b0;
      end else begin
         waited <= waited + 8'h01;
         nv_done_o <= (waited >= lat_i);
      end
   end
endmodule : scs_nv_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench of the serial command settings block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, v;
   logic wb_ack_o, nv_req_o, nv_data_o, nv_done_i, hang_up_o;
   logic tone_det_i = 1'b0, drop_det_i = 1'b0;
   logic signed [7:0] agc_target_i = 8'sh00;
   logic signed [7:0] agc_gain_o;
   logic [15:0] baud_div_o;
   logic [7:0] lat = 8'h02;
   int miscompares = 0, total_checks = 0, cycles = 0, i, j;
   logic [2:0] bs [3] = '{scs_pkg::SET_AGC, scs_pkg::SET_TONE, scs_pkg::SET_DROP};
   logic [7:0] bc [3] = '{scs_pkg::CHAN_T, 8'h00, 8'h00};
   logic [7:0] bd [5] = '{8'h01, 8'h00, 8'h02, 8'h3F, 8'h02};
   logic [7:0] be [5] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00};
   // Integer table: setting, data, error, echoed value.
   logic [19:0] it [13] = '{{3'h2, 8'h0F, 1'b0, 8'h0F}, {3'h2, 8'h10, 1'b1, 8'h10},
      {3'h2, 8'h00, 1'b0, 8'h00}, {3'h2, 8'h3F, 1'b0, 8'h00}, {3'h3, 8'hF1, 1'b0, 8'hF1},
      {3'h3, 8'hF0, 1'b1, 8'hF0}, {3'h3, 8'h01, 1'b1, 8'h01}, {3'h3, 8'h00, 1'b0, 8'h00},
      {3'h3, 8'h3F, 1'b0, 8'h00}, {3'h4, 8'h01, 1'b0, 8'h01}, {3'h4, 8'h05, 1'b0, 8'h05},
      {3'h4, 8'h00, 1'b1, 8'h00}, {3'h4, 8'h06, 1'b1, 8'h06}};

   always #2 clk_i = ~clk_i;

   scs_command_settings #(.RAMP_SEC_CYCLES(20)) scs_command_settings_inst (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .nv_req_o(nv_req_o), .nv_data_o(nv_data_o),
      .nv_done_i(nv_done_i), .tone_det_i(tone_det_i), .drop_det_i(drop_det_i),
      .hang_up_o(hang_up_o), .agc_target_i(agc_target_i), .agc_gain_o(agc_gain_o),
      .baud_div_o(baud_div_o));

   scs_nv_model scs_nv_model_inst (.clk_i(clk_i), .rst_i(rst_i), .nv_req_i(nv_req_o),
      .lat_i(lat), .nv_done_o(nv_done_i));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      v = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task automatic cmd(input logic [2:0] s, input logic [1:0] op, input logic [7:0] c,
      input logic [7:0] d);
      wb(1'b1, scs_pkg::ADR_CMD, {8'h00, d, c, 3'h0, op, s});
   endtask : cmd

   task automatic reply(input logic ev, input logic err, input logic [2:0] s,
      input logic [7:0] c, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         wb(1'b0, scs_pkg::ADR_REPLY, 32'h0);
         n++;
      end while (v[31] !== 1'b1 && n < 30);
      if (ev) check(v, {1'b1, err, 11'h000, s, c, d}, "reply word");
      else check({31'h0, v[31]}, 32'h0, "no reply");
   endtask : reply

   task automatic hits(input logic tone, input int exp);
      int n;
      n = 0;
      @(posedge clk_i);
      tone_det_i <= tone;
      drop_det_i <= !tone;
      repeat (20) begin
         @(posedge clk_i);
         if (hang_up_o === 1'b1) n++;
         if (n == 0) begin
            tone_det_i <= tone_det_i;
         end
      end
      tone_det_i <= 1'b0;
      drop_det_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      check(32'(n), 32'(exp), "hangup pulses");
   endtask : hits

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      wb(1'b0, scs_pkg::ADR_STAT, 32'h0);
      check({27'h0, v[4:0]}, 32'h1, "status after reset");
      check({16'h0, baud_div_o}, 32'h65B9, "reset divisor");
      $display("test reset done");
      for (i = 0; i < 3; i++) for (j = 0; j < 5; j++) begin
         cmd(bs[i], scs_pkg::OP_CMD, bc[i], bd[j]);
         reply(1'b1, 1'b0, bs[i], bc[i], be[j]);
      end
      cmd(scs_pkg::SET_AGC, scs_pkg::OP_CMD, 8'h41, 8'h01);
      reply(1'b1, 1'b1, scs_pkg::SET_AGC, 8'h41, 8'h01);
      $display("test booleans done");
      for (i = 0; i < 13; i++) begin
         cmd(it[i][19:17], scs_pkg::OP_CMD, scs_pkg::CHAN_T, it[i][16:9]);
         reply(1'b1, it[i][8], it[i][19:17], scs_pkg::CHAN_T, it[i][7:0]);
      end
      $display("test integers done");
      cmd(scs_pkg::SET_AGC, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h01);
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h03);
      cmd(scs_pkg::SET_FLOOR, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'hFD);
      reply(1'b1, 1'b0, scs_pkg::SET_FLOOR, scs_pkg::CHAN_T, 8'hFD);
      agc_target_i <= 8'sh0A;
      repeat (150) @(posedge clk_i);
      check({24'h0, agc_gain_o}, 32'h03, "gain at ceiling");
      agc_target_i <= -8'sh0A;
      repeat (150) @(posedge clk_i);
      check({24'h0, agc_gain_o}, 32'hFD, "gain at floor");
      cmd(scs_pkg::SET_RATE, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h01);
      agc_target_i <= 8'sh0A;
      repeat (30) @(posedge clk_i);
      check({31'h0, agc_gain_o <= -8'sd1}, 32'h1, "slow ramp");
      repeat (200) @(posedge clk_i);
      check({24'h0, agc_gain_o}, 32'h03, "ramp settles");
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_SAVE, scs_pkg::CHAN_T, 8'h00);
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h0A);
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_RECALL, scs_pkg::CHAN_T, 8'h00);
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h3F);
      reply(1'b1, 1'b0, scs_pkg::SET_CEIL, scs_pkg::CHAN_T, 8'h03);
      $display("test gain and preset done");
      cmd(scs_pkg::SET_TONE, scs_pkg::OP_CMD, 8'h00, 8'h01);
      hits(1'b0, 0);
      hits(1'b1, 1);
      cmd(scs_pkg::SET_TONE, scs_pkg::OP_CMD, 8'h00, 8'h00);
      cmd(scs_pkg::SET_DROP, scs_pkg::OP_CMD, 8'h00, 8'h01);
      hits(1'b1, 0);
      hits(1'b0, 1);
      $display("test hangup done");
      reply(1'b1, 1'b0, scs_pkg::SET_DROP, 8'h00, 8'h01);
      lat <= 8'h14;
      cmd(scs_pkg::SET_REPLY, scs_pkg::OP_CMD, 8'h00, 8'h00);
      check({31'h0, nv_req_o & ~nv_data_o}, 32'h1, "storage write off");
      reply(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
      cmd(scs_pkg::SET_AGC, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h3F);
      reply(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
      cmd(scs_pkg::SET_REPLY, scs_pkg::OP_CMD, 8'h00, 8'h02);
      check({31'h0, nv_req_o & nv_data_o}, 32'h1, "storage write on");
      wb(1'b0, scs_pkg::ADR_REPLY, 32'h0);
      check({31'h0, v[31]}, 32'h0, "reply held back");
      reply(1'b1, 1'b0, scs_pkg::SET_REPLY, 8'h00, 8'h01);
      $display("test reply enable done");
      wb(1'b1, scs_pkg::ADR_BAUD, 32'h1);
      @(posedge clk_i);
      check({16'h0, baud_div_o}, 32'h32DC, "divisor 19200");
      wb(1'b1, scs_pkg::ADR_BAUD, 32'h2);
      wb(1'b1, scs_pkg::ADR_BAUD, 32'h3);
      check({16'h0, baud_div_o}, 32'h196E, "divisor 38400");
      wb(1'b1, scs_pkg::ADR_BAUD, 32'h0);
      @(posedge clk_i);
      check({16'h0, baud_div_o}, 32'h65B9, "divisor 9600");
      wb(1'b1, 5'h14, 32'hFFFFFFFF);
      wb(1'b0, 5'h14, 32'h0);
      check(v, 32'h0, "unmapped read");
      $display("test port rate done");
      wb(1'b1, scs_pkg::ADR_BOOT, 32'h1);
      wb(1'b0, scs_pkg::ADR_BOOT, 32'h0);
      check(v, 32'h1, "boot choice");
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      cmd(scs_pkg::SET_CEIL, scs_pkg::OP_CMD, scs_pkg::CHAN_T, 8'h3F);
      reply(1'b1, 1'b0, scs_pkg::SET_CEIL, scs_pkg::CHAN_T, 8'h03);
      $display("test preset restore done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
